// File: core/capture_consts.vh
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH

// Register offsets (byte addresses)
`define OFF_GATE_SET    8'h50
`define OFF_GATE_CLEAR  8'h54
`define OFF_GATE_STATE  8'h58
`define OFF_COMMAND     8'h60
`define OFF_MODE        8'h64
`define OFF_COUNT       8'h6c
`define OFF_FLAGS       8'h70
`define OFF_CAPT_A      8'h74
`define OFF_CAPT_B      8'h78
`define OFF_COMPARE_C   8'h7c

// Gate bits
`define GATE_PIN        0
`define GATE_TIMER      1

// Command bits
`define CMD_SOFT_RESET  0
`define CMD_CLOCK_ON    1
`define CMD_CLOCK_OFF   2
`define CMD_TRIGGER     3

// Mode fields
`define MODE_CLKSEL_LO  0
`define MODE_INVERT     3
`define MODE_BURST_LO   4
`define MODE_LDB_STOP   6
`define MODE_LDB_DIS    7
`define MODE_TRGEDG_LO  8
`define MODE_TRIG_ON_A  10
`define MODE_CMP_TRIG   14
`define MODE_WAVE       15
`define MODE_LDA_LO     16
`define MODE_LDB_LO     18
`define MODE_MASK       32'h000fc7ff
`define MODE_RESET      32'h00000000

// Flag bits
`define FLG_OVF         0
`define FLG_OVR         1
`define FLG_CMP         4
`define FLG_LDA         5
`define FLG_LDB         6
`define FLG_TRG         7
`define FLG_CLKSTA      8
`define FLG_MIRROR_A    9
`define FLG_MIRROR_B    10
`define FLG_CHG_B       16
`define FLG_CHG_A       17
`define FLG_CHG_X       18
`define FLG_STICKY      19'h700f3

// Clock select codes
`define CLKSEL_DIV2     3'h0
`define CLKSEL_DIV8     3'h1
`define CLKSEL_DIV32    3'h2
`define CLKSEL_DIV128   3'h3
`define CLKSEL_DIV1024  3'h4
`define CLKSEL_EXT0     3'h5
`define CLKSEL_EXT1     3'h6
`define CLKSEL_EXT2     3'h7

`define COUNT_MAX       16'hffff
`define GATE_RESET      2'h0

`endif

// File: core/timer_channel_capture_mode.v
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "capture_consts.vh"

module timer_channel_capture_mode (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdData,
  // Group trigger from the shared synchronisation register
  input  wire        groupTrigger,
  // Timer pins
  input  wire        primaryTimerPin,
  input  wire        secondaryTimerPin,
  input  wire        externalCountClockPin,
  output reg         primaryPinOut,
  output reg         primaryPinOe,
  output reg         secondaryPinOut,
  output reg         secondaryPinOe,
  // External clock lines
  input  wire [2:0]  externalClock,
  // Clock gate state
  output reg         pinControllerClockOn,
  output reg         timerChannelClockOn
);

  // Edge condition decode shared by trigger and both loads
  function edgeHit;
    input [1:0] cfg;
    input       rise;
    input       fall;
    begin
      edgeHit = (cfg[0] & rise) | (cfg[1] & fall);
    end
  endfunction

  // Prescaler tick for a divided core clock
  function divTick;
    input [2:0] sel;
    input [9:0] div;
    begin
      case (sel)
        `CLKSEL_DIV2:    divTick = div[0];
        `CLKSEL_DIV8:    divTick = &div[2:0];
        `CLKSEL_DIV32:   divTick = &div[4:0];
        `CLKSEL_DIV128:  divTick = &div[6:0];
        `CLKSEL_DIV1024: divTick = &div[9:0];
        default:         divTick = 1'b0;
      endcase
    end
  endfunction

  // Pin synchronisers: {ext2, ext1, ext0, count pin, secondary, primary}
  reg  [5:0]  pinMeta;
  reg  [5:0]  pinSync;
  reg  [5:0]  pinPrev;

  // Register state
  reg  [31:0] modeReg;
  reg  [15:0] compareC;
  reg  [15:0] captureA;
  reg  [15:0] captureB;
  reg  [15:0] count;
  reg  [9:0]  prescale;
  reg  [18:0] flags;
  reg         counterClockOn;
  reg         running;
  reg         pendingTrig;
  reg         aLoaded;
  reg         aUnread;
  reg         bUnread;

  // Decoded strokes
  wire wrCmd     = regWrite & (regAddr == `OFF_COMMAND);
  wire softReset = wrCmd & regWrData[`CMD_SOFT_RESET];
  wire flagsRead = regRead & (regAddr == `OFF_FLAGS);
  wire readA     = regRead & (regAddr == `OFF_CAPT_A);
  wire readB     = regRead & (regAddr == `OFF_CAPT_B);

  // Mode fields
  wire [2:0] clkSel   = modeReg[`MODE_CLKSEL_LO +: 3];
  wire       clkInv   = modeReg[`MODE_INVERT];
  wire [1:0] burstSel = modeReg[`MODE_BURST_LO +: 2];
  wire       ldbStop  = modeReg[`MODE_LDB_STOP];
  wire       ldbDis   = modeReg[`MODE_LDB_DIS];
  wire [1:0] trgEdge  = modeReg[`MODE_TRGEDG_LO +: 2];
  wire       trigOnA  = modeReg[`MODE_TRIG_ON_A];
  wire       cmpTrig  = modeReg[`MODE_CMP_TRIG];
  wire       capMode  = ~modeReg[`MODE_WAVE];
  wire [1:0] ldaEdge  = modeReg[`MODE_LDA_LO +: 2];
  wire [1:0] ldbEdge  = modeReg[`MODE_LDB_LO +: 2];

  // Edges on synchronised pins
  wire [5:0] rise = pinSync & ~pinPrev;
  wire [5:0] fall = ~pinSync & pinPrev;
  wire [5:0] chg  = pinSync ^ pinPrev;

  // Clock source: CLKI picks the falling edge of an external line
  reg  extTick;
  always @* begin
    case (clkSel)
      `CLKSEL_EXT0: extTick = clkInv ? fall[3] : rise[3];
      `CLKSEL_EXT1: extTick = clkInv ? fall[4] : rise[4];
      `CLKSEL_EXT2: extTick = clkInv ? fall[5] : rise[5];
      default:      extTick = 1'b0;
    endcase
  end

  // Burst gate is the synchronised level of the chosen line
  reg  burstOk;
  always @* begin
    case (burstSel)
      2'h1:    burstOk = pinSync[3];
      2'h2:    burstOk = pinSync[4];
      2'h3:    burstOk = pinSync[5];
      default: burstOk = 1'b1;
    endcase
  end

  // Codes 5 to 7 take an external line, lower codes the prescaler
  wire srcTick = clkSel[2] & (clkSel[1] | clkSel[0]) ? extTick
               : divTick(clkSel, prescale);
  wire cntTick = srcTick & burstOk & counterClockOn
               & timerChannelClockOn;

  // Capture events on primary pin edges, trigger on primary or secondary
  wire loadA = capMode & edgeHit(ldaEdge, rise[0], fall[0]);
  wire loadB = capMode & aLoaded
             & edgeHit(ldbEdge, rise[0], fall[0]);
  wire extTrigRaw = capMode & (trigOnA
                  ? edgeHit(trgEdge, rise[0], fall[0])
                  : edgeHit(trgEdge, rise[1], fall[1]));
  // Trigger loses when the same edge loads B and stops the counter
  wire stopByB  = loadB & (ldbStop | ldbDis);
  wire extTrig  = extTrigRaw & ~stopByB;

  // Counter next value
  wire        startNow  = cntTick & pendingTrig;
  wire        stepNow   = cntTick & running & ~pendingTrig;
  wire [15:0] nextCount = startNow ? 16'h0000
                        : stepNow  ? count + 16'h0001 : count;
  wire overflow = stepNow & (count == `COUNT_MAX);
  wire cmpHit   = (startNow | stepNow)
                & (nextCount == compareC);

  // Clock enable command, off wins over on
  wire clkOnCmd  = wrCmd & regWrData[`CMD_CLOCK_ON]
                 & ~regWrData[`CMD_CLOCK_OFF];
  wire clkOffCmd = wrCmd & regWrData[`CMD_CLOCK_OFF];
  wire swTrig    = wrCmd & regWrData[`CMD_TRIGGER];

  wire trigReq = swTrig | groupTrigger | extTrig
               | (cmpTrig & cmpHit);
  wire overrun = (loadA & aUnread) | (loadB & bUnread);

  // Sticky event flags in status layout
  reg  [18:0] setVec;
  always @* begin
    setVec              = 19'h00000;
    setVec[`FLG_OVF]    = overflow;
    setVec[`FLG_OVR]    = overrun;
    setVec[`FLG_CMP]    = cmpHit;
    setVec[`FLG_LDA]    = loadA;
    setVec[`FLG_LDB]    = loadB;
    setVec[`FLG_TRG]    = extTrig;
    setVec[`FLG_CHG_A]  = chg[0];
    setVec[`FLG_CHG_B]  = chg[1];
    setVec[`FLG_CHG_X]  = chg[2];
  end

  // Read clears, but an event in the same cycle survives
  wire [18:0] next_flags = ((flagsRead ? 19'h00000 : flags) | setVec)
                         & `FLG_STICKY;

  // Two-stage synchronisers; the first stage feeds only the second
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
      pinPrev <= 6'h00;
    end else begin
      pinMeta <= {externalClock, externalCountClockPin,
                  secondaryTimerPin, primaryTimerPin};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // Reset pattern of both gates, one bit per gate
  localparam [1:0] GATE_INIT = `GATE_RESET;

  // Clock gate state survives soft reset so software keeps its power plan
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinControllerClockOn <= GATE_INIT[`GATE_PIN];
      timerChannelClockOn  <= GATE_INIT[`GATE_TIMER];
    end else if (regWrite && regAddr == `OFF_GATE_SET) begin
      if (regWrData[`GATE_PIN]) begin
        pinControllerClockOn <= 1'b1;
      end
      if (regWrData[`GATE_TIMER]) begin
        timerChannelClockOn <= 1'b1;
      end
    end else if (regWrite && regAddr == `OFF_GATE_CLEAR) begin
      if (regWrData[`GATE_PIN]) begin
        pinControllerClockOn <= 1'b0;
      end
      if (regWrData[`GATE_TIMER]) begin
        timerChannelClockOn <= 1'b0;
      end
    end
  end

  // Prescaler runs only while the timer channel clock is gated on
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 10'h000;
    end else if (softReset || !timerChannelClockOn) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // Pins stay inputs; waveform drive is not part of this channel
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      primaryPinOut   <= 1'b0;
      primaryPinOe    <= 1'b0;
      secondaryPinOut <= 1'b0;
      secondaryPinOe  <= 1'b0;
    end else begin
      primaryPinOut   <= 1'b0;
      primaryPinOe    <= 1'b0;
      secondaryPinOut <= 1'b0;
      secondaryPinOe  <= 1'b0;
    end
  end

  // Software-written configuration
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg  <= `MODE_RESET;
      compareC <= 16'h0000;
    end else if (softReset) begin
      modeReg  <= `MODE_RESET;
      compareC <= 16'h0000;
    end else if (regWrite) begin
      if (regAddr == `OFF_MODE) begin
        modeReg <= regWrData & `MODE_MASK;
      end
      if (regAddr == `OFF_COMPARE_C) begin
        compareC <= regWrData[15:0];
      end
    end
  end

  // Counter, trigger and counter clock control
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count          <= 16'h0000;
      running        <= 1'b0;
      pendingTrig    <= 1'b0;
      counterClockOn <= 1'b0;
    end else if (softReset) begin
      count          <= 16'h0000;
      running        <= 1'b0;
      pendingTrig    <= 1'b0;
      counterClockOn <= 1'b0;
    end else begin
      count <= nextCount;
      // Disabling the clock also stops the counter
      if (clkOffCmd || (loadB && ldbDis)) begin
        counterClockOn <= 1'b0;
        running        <= 1'b0;
        pendingTrig    <= 1'b0;
      end else begin
        if (clkOnCmd) begin
          counterClockOn <= 1'b1;
        end
        if (loadB && ldbStop) begin
          running <= 1'b0;
        end else if (startNow) begin
          running <= 1'b1;
        end
        // A trigger waits for the next counter tick; none while clock off
        pendingTrig <= (counterClockOn | clkOnCmd)
                     & (trigReq | (pendingTrig & ~cntTick));
      end
    end
  end

  // Capture registers and their unread tracking
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      captureA <= 16'h0000;
      captureB <= 16'h0000;
      aLoaded  <= 1'b0;
      aUnread  <= 1'b0;
      bUnread  <= 1'b0;
    end else if (softReset) begin
      captureA <= 16'h0000;
      captureB <= 16'h0000;
      aLoaded  <= 1'b0;
      aUnread  <= 1'b0;
      bUnread  <= 1'b0;
    end else begin
      if (loadA) begin
        captureA <= count;
      end
      if (loadB) begin
        captureB <= count;
      end
      // B waits for A so that a period spans one full cycle
      if (loadB) begin
        aLoaded <= 1'b0;
      end else if (loadA) begin
        aLoaded <= 1'b1;
      end
      aUnread <= loadA | (aUnread & ~readA);
      bUnread <= loadB | (bUnread & ~readB);
    end
  end

  // Event flags
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 19'h00000;
    end else if (softReset) begin
      flags <= 19'h00000;
    end else begin
      flags <= next_flags;
    end
  end

  // Live status bits: clock status and pin mirrors
  reg  [31:0] statusWord;
  always @*  begin
    statusWord                = {13'h0000, flags};
    statusWord[`FLG_CLKSTA]   = counterClockOn;
    statusWord[`FLG_MIRROR_A] = pinSync[0];
    statusWord[`FLG_MIRROR_B] = pinSync[1];
  end

  // Read mux; write-only and unmapped offsets read as zero
  reg  [31:0] next_rdData;
  always @* begin
    case (regAddr)
      `OFF_GATE_STATE: next_rdData = {30'h00000000,
                         timerChannelClockOn,
                         pinControllerClockOn};
      `OFF_MODE:       next_rdData = modeReg;
      `OFF_COUNT:      next_rdData = {16'h0000, count};
      `OFF_FLAGS:      next_rdData = statusWord;
      `OFF_CAPT_A:     next_rdData = {16'h0000, captureA};
      `OFF_CAPT_B:     next_rdData = {16'h0000, captureB};
      `OFF_COMPARE_C:  next_rdData = {16'h0000, compareC};
      default:         next_rdData = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the read strobe
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 32'h00000000;
    end else if (regRead) begin
      regRdData <= next_rdData;
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule

// File: dv/capture_mode_asserts.sv
`timescale 1ns/10ps
`include "capture_consts.vh"

module capture_mode_asserts (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // Register port
  input wire [7:0]  regAddr,
  input wire [31:0] regWrData,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regRdData,
  // Pin enables and clock gates
  input wire        primaryPinOe,
  input wire        secondaryPinOe,
  input wire        pinControllerClockOn,
  input wire        timerChannelClockOn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Decoded strobes shared by several properties
  wire [1:0] gate = {timerChannelClockOn, pinControllerClockOn};
  wire       gSet = regWrite && regAddr == `OFF_GATE_SET;
  wire       gClr = regWrite && regAddr == `OFF_GATE_CLEAR;
  wire       cWr  = regWrite && regAddr == `OFF_COMMAND;
  wire       fRd  = regRead && regAddr == `OFF_FLAGS;
  wire       mWr  = regWrite && regAddr == `OFF_MODE;
  wire       mRd  = regRead && regAddr == `OFF_MODE;
  wire       woRd = regRead && (regAddr == `OFF_GATE_SET ||
                    regAddr == `OFF_GATE_CLEAR || regAddr == `OFF_COMMAND);

  chk_pins_input: assert property (!primaryPinOe && !secondaryPinOe)
    else $error("timer pin driven in capture mode");
  chk_gate_set: assert property (
    gSet |=> gate == ($past(gate) | $past(regWrData[1:0])))
    else $error("gate set write misapplied");
  chk_gate_clear: assert property (
    gClr |=> gate == ($past(gate) & ~$past(regWrData[1:0])))
    else $error("gate clear write misapplied");
  // Soft reset and other writes must leave the gates alone
  chk_gate_hold: assert property (!(gSet || gClr) |=> $stable(gate))
    else $error("gate state moved without a gate write");
  chk_state_read: assert property (
    regRead && regAddr == `OFF_GATE_STATE
    |=> regRdData == {30'h0, $past(gate)})
    else $error("gate state read wrong");
  chk_wo_reads: assert property (woRd |=> regRdData == 32'h0)
    else $error("write-only register returned data");
  chk_clock_off: assert property (
    cWr && regWrData[2] ##2 fRd |=> !regRdData[`FLG_CLKSTA])
    else $error("counter clock still on after off command");
  chk_clock_on: assert property (
    cWr && regWrData[2:0] == 3'h2 && timerChannelClockOn ##2 fRd
    |=> regRdData[`FLG_CLKSTA])
    else $error("counter clock not on after on command");
  chk_mode_read: assert property (
    mWr ##2 mRd |=> regRdData == ($past(regWrData, 3) & `MODE_MASK))
    else $error("mode readback wrong");
endmodule

bind timer_channel_capture_mode capture_mode_asserts chk (
  .sys_clk              (sys_clk),
  .rst_n                (rst_n),
  .regAddr              (regAddr),
  .regWrData            (regWrData),
  .regWrite             (regWrite),
  .regRead              (regRead),
  .regRdData            (regRdData),
  .primaryPinOe         (primaryPinOe),
  .secondaryPinOe       (secondaryPinOe),
  .pinControllerClockOn (pinControllerClockOn),
  .timerChannelClockOn  (timerChannelClockOn)
);

// File: dv/pin_event_source.sv
`timescale 1ns/10ps

module pin_event_source (
  // Clock
  input  wire       sys_clk,
  // Pins toward the channel
  output reg        primaryTimerPin,
  output reg        secondaryTimerPin,
  output reg        externalCountClockPin,
  output reg  [2:0] externalClock
);
  // Pins idle low; every level is held past the two-stage synchroniser
  initial begin
    primaryTimerPin = 1'b0;
    secondaryTimerPin = 1'b0;
    externalCountClockPin = 1'b0;
    externalClock = 3'h0;
  end

  // One high pulse on the primary pin; side pins toggle for change flags
  task pulse(input int width);
    @(posedge sys_clk);
    primaryTimerPin <= 1'b1;
    secondaryTimerPin <= ~secondaryTimerPin;
    repeat (width) @(posedge sys_clk);
    primaryTimerPin <= 1'b0;
    externalCountClockPin <= ~externalCountClockPin;
    repeat (width) @(posedge sys_clk);
  endtask

  // Rising edges on one external clock line, slow against the core clock
  task ticks(input int line, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      externalClock[line] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      externalClock[line] <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule

// File: dv/timer_channel_capture_mode_tb_top.sv
`timescale 1ns/10ps
`include "capture_consts.vh"

module timer_channel_capture_mode_tb_top;
  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrite;
  logic        regRead;
  logic        groupTrigger;
  logic [31:0] rdVal;
  logic [31:0] capA;
  logic [31:0] rnd;
  wire  [31:0] regRdData;
  wire         priPin, secPin, cntPin, priOut, priOe, secOut, secOe;
  wire         pinControllerClockOn, timerChannelClockOn;
  wire  [2:0]  extClk;
  int          errors, testsRun, gateModel, clkModel, countModel;
  // Reference tables for the looped cases
  logic [7:0]  gAddr[5] = '{`OFF_GATE_SET, `OFF_GATE_SET, `OFF_GATE_CLEAR,
                            `OFF_GATE_CLEAR, `OFF_GATE_SET};
  int          gDat[5] = '{1, 2, 1, 0, 0};
  logic [7:0]  zeroAt[6] = '{`OFF_GATE_SET, `OFF_GATE_CLEAR, `OFF_COMMAND,
                             `OFF_GATE_STATE, `OFF_MODE, 8'h08};
  int          cmds[4] = '{6, 2, 4, 2};
  int          sel[5] = '{5, 6, 7, 5, 13};
  int          burst[5] = '{0, 0, 0, 2, 0};
  int          line[5] = '{0, 1, 2, 0, 0};

  timer_channel_capture_mode dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .groupTrigger(groupTrigger),
    .primaryTimerPin(priPin), .secondaryTimerPin(secPin),
    .externalCountClockPin(cntPin), .primaryPinOut(priOut),
    .primaryPinOe(priOe), .secondaryPinOut(secOut), .secondaryPinOe(secOe),
    .externalClock(extClk), .pinControllerClockOn(pinControllerClockOn),
    .timerChannelClockOn(timerChannelClockOn));

  pin_event_source pins (
    .sys_clk(sys_clk), .primaryTimerPin(priPin), .secondaryTimerPin(secPin),
    .externalCountClockPin(cntPin), .externalClock(extClk));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Bus cycles: one-cycle strobes launched just after a rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  // Read data only stands for one cycle, so it is taken just past the edge
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task checkReg(input string what, input logic [31:0] exp, got);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task checkPort(input string what, input logic [1:0] exp, got);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task wrap_up();
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run needs a few hundred cycles; this limit only catches a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    groupTrigger = 1'b0;
    rnd = 32'h93a7;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset state: capture mode, gates off, write-only places read zero
    foreach (zeroAt[i]) begin
      rd(zeroAt[i], rdVal);
      checkReg("reset read", 32'h0, rdVal);
    end
    checkPort("pin enables", 2'b00, {priOe, secOe});
    checkPort("pin outputs", 2'b00, {priOut, secOut});
    $display("test reset done");
    // Each gate moves only where a one is written
    for (int i = 0; i < 5; i++) begin
      wr(gAddr[i], gDat[i]);
      gateModel = (gAddr[i] == `OFF_GATE_SET) ? (gateModel | gDat[i])
                                              : (gateModel & ~gDat[i]);
      rd(`OFF_GATE_STATE, rdVal);
      checkReg("gate state", gateModel, rdVal);
      checkPort("gate ports", gateModel[1:0],
                {timerChannelClockOn, pinControllerClockOn});
    end
    $display("test gates done");
    // Off beats on when both are written together
    foreach (cmds[i]) begin
      wr(`OFF_COMMAND, cmds[i]);
      clkModel = cmds[i][2] ? 0 : (cmds[i][1] ? 1 : clkModel);
      rd(`OFF_FLAGS, rdVal);
      checkReg("clock status", clkModel, rdVal[8]);
    end
    rnd = lfsr(rnd);
    wr(`OFF_COMPARE_C, rnd);
    rd(`OFF_COMPARE_C, rdVal);
    checkReg("compare c", {16'h0, rnd[15:0]}, rdVal);
    $display("test clock control done");
    // External counting; first tick restarts; row 3 gated off, row 4 on falls
    wr(`OFF_COMPARE_C, 32'h3);
    foreach (sel[i]) begin
      wr(`OFF_MODE, (burst[i] << 4) | sel[i]);
      rd(`OFF_FLAGS, rdVal);
      if (i == 1) begin
        @(posedge sys_clk);
        groupTrigger <= 1'b1;
        @(posedge sys_clk);
        groupTrigger <= 1'b0;
      end else
        wr(`OFF_COMMAND, 32'h8);
      pins.ticks(line[i], 4);
      repeat (6) @(posedge sys_clk);
      if (burst[i] == 0)
        countModel = 3;
      rd(`OFF_COUNT, rdVal);
      checkReg("count", countModel, rdVal);
      rd(`OFF_FLAGS, rdVal);
      checkReg("compare flag", burst[i] == 0, rdVal[4]);
    end
    $display("test counting done");
    // Rise loads A, fall loads B and restarts, counted at core/2
    wr(`OFF_MODE, 32'h00090600);
    rd(`OFF_MODE, rdVal);
    checkReg("mode", 32'h00090600 & `MODE_MASK, rdVal);
    rd(`OFF_FLAGS, rdVal);
    pins.pulse(8);
    repeat (6) @(posedge sys_clk);
    rd(`OFF_FLAGS, rdVal);
    checkReg("capture flags", 32'he0, rdVal & 32'he3);
    rd(`OFF_FLAGS, rdVal);
    checkReg("flags cleared", 32'h0, rdVal & 32'he3);
    rd(`OFF_CAPT_A, capA);
    rd(`OFF_CAPT_B, rdVal);
    checkReg("pulse width", 32'h4, (rdVal - capA) & 32'hffff);
    pins.pulse(8);
    pins.pulse(8);
    repeat (6) @(posedge sys_clk);
    rd(`OFF_FLAGS, rdVal);
    checkReg("overrun flags", 32'he2, rdVal & 32'he3);
    $display("test capture done");
    // Soft reset clears the channel but keeps the gate state
    wr(`OFF_COMMAND, 32'h1);
    rd(`OFF_MODE, rdVal);
    checkReg("mode after reset", 32'h0, rdVal);
    rd(`OFF_COMPARE_C, rdVal);
    checkReg("compare after reset", 32'h0, rdVal);
    rd(`OFF_GATE_STATE, rdVal);
    checkReg("gate after reset", gateModel, rdVal);
    rd(`OFF_FLAGS, rdVal);
    checkReg("clock after reset", 32'h0, rdVal[8]);
    $display("test soft reset done");
    // Loading B with stop and disable set freezes the counter
    wr(`OFF_COMMAND, 32'h2);
    wr(`OFF_MODE, 32'h000906c0);
    wr(`OFF_COMMAND, 32'h8);
    pins.pulse(8);
    repeat (6) @(posedge sys_clk);
    rd(`OFF_COUNT, capA);
    repeat (8) @(posedge sys_clk);
    rd(`OFF_COUNT, rdVal);
    checkReg("stopped count", capA, rdVal);
    rd(`OFF_FLAGS, rdVal);
    checkReg("clock after load b", 32'h0, rdVal[8]);
    $display("test load stop done");
    wrap_up();
  end
endmodule
